// ### vfcfg_pkg.sv
// Constants for the per-VF configuration register bank
package vfcfg_pkg;

   // ***************************************************************
   // Register offsets (byte addresses in a VF's configuration space)
   // ***************************************************************
   localparam logic [11:0] OFS_CMD_STATUS   = 12'h004;
   localparam logic [11:0] OFS_DEV_CAPS2    = 12'h054;
   localparam logic [11:0] OFS_DEV_CTRL2    = 12'h058;
   localparam logic [11:0] OFS_LINK_CAPS2   = 12'h05c;
   localparam logic [11:0] OFS_LINK_CTRL2   = 12'h060;
   localparam logic [11:0] OFS_ARI_HEADER   = 12'h100;
   localparam logic [11:0] OFS_ARI_CAP_CTRL = 12'h104;
   localparam logic [11:0] OFS_TPH_HEADER   = 12'h300;
   localparam logic [11:0] OFS_TPH_CAP      = 12'h304;
   localparam logic [11:0] OFS_TPH_CTRL     = 12'h308;
   localparam logic [11:0] OFS_ATS_HEADER   = 12'h3c0;
   localparam logic [11:0] OFS_ATS_CAP_CTRL = 12'h3c4;

   // ***************************************************************
   // Command/Status and Link Ctrl2 field positions
   // ***************************************************************
   localparam int CMD_BME_BIT    = 2;
   localparam int STS_EXTCAP_BIT = 20;
   localparam int STS_MDPE_BIT   = 24;
   localparam int STS_STA_BIT    = 27;
   localparam int STS_RTA_BIT    = 28;
   localparam int STS_RMA_BIT    = 29;
   localparam int STS_SSE_BIT    = 30;
   localparam int STS_RUR_BIT    = 31;
   localparam int DEEMPH_BIT     = 16;

   // Error flag slots inside the per-VF flag vector
   localparam int FLG_MDPE = 0;
   localparam int FLG_STA  = 1;
   localparam int FLG_RTA  = 2;
   localparam int FLG_RMA  = 3;
   localparam int FLG_SSE  = 4;
   localparam int FLG_RUR  = 5;
   localparam int FLG_NUM  = 6;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic        BME_RST      = 1'b0;
   localparam logic [5:0]  FLAGS_RST    = 6'h00;
   localparam logic [31:0] TPH_CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] ATS_CTRL_RST = 16'h0000;

   // ***************************************************************
   // Capability headers and fixed content
   // ***************************************************************
   localparam logic [15:0] ARI_CAP_ID   = 16'h000e;
   localparam logic [15:0] TPH_CAP_ID   = 16'h0017;
   localparam logic [15:0] ATS_CAP_ID   = 16'h000f;
   localparam logic [3:0]  CAP_VERSION  = 4'h1;
   localparam logic [11:0] NEXT_NULL    = 12'h000;
   localparam logic [11:0] TPH_NEXT_PTR = 12'h3c0;
   localparam logic [31:0] TPH_CAP_VAL  = 32'h0000_0001;
   localparam logic [15:0] ATS_CAP_VAL  = 16'h0020;
   // Writable bits: TPH mode select [2:0], enable [9:8]; ATS STU [4:0], enable [15]
   localparam logic [31:0] TPH_CTRL_WMASK = 32'h0000_0307;
   localparam logic [15:0] ATS_CTRL_WMASK = 16'h801f;

endpackage : vfcfg_pkg

// ### vfcfg_regs.sv
// Per-VF configuration register bank: mirrors, hardwired words, Command/Status flags
`timescale 1ns/10ps
// What this block does
// R1: Device Caps 2 read returns parent PF value
// R2: Three unimplemented locations always read zero
// R3: Link Ctrl2 bit 16 shows PF de-emphasis
// R4: ARI header with ARI ID, null next
// R5: TPH header, capability and control words
// R6: ATS header; 16-bit capability plus control
// R7: Bit 2 bus-master enable, RW, resets 0
// R8: Bit 20 always reads one
// R9: Bit 24 set on poison, if PF PERR enabled
// R10: Bit 27 set on sent Completer Abort
// R11: Bit 28 set on received Completer Abort
// R12: Bit 29 set on received Unsupported Request
// R13: Bit 30 set on error message, if SERR
// R14: Bit 31 set on received Unsupported Request
// R15: Error flags reset 0, write one clears
// R16: Up to 2048 VFs, each own copy
// R17: Reserved and hardwired writes ignored, reserved zero
module vfcfg_regs #(
   parameter int NUM_VF = 2048,
   parameter int VF_W   = (NUM_VF > 1) ? $clog2(NUM_VF) : 1
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // Configuration access port
   input  wire logic [VF_W-1:0]   cfg_vf_i,
   input  wire logic [11:0]       cfg_addr_i,
   input  wire logic [31:0]       cfg_wdata_i,
   input  wire logic              cfg_wr_i,
   input  wire logic              cfg_rd_i,
   output logic      [31:0]       cfg_rdata_o,
   // Parent PF settings
   input  wire logic [31:0]       pf_dev_caps2_i,
   input  wire logic              pf_deemph_i,
   input  wire logic              pf_perr_en_i,
   input  wire logic              pf_serr_en_i,
   // Error events, all for the VF on evt_vf_i
   input  wire logic [VF_W-1:0]   evt_vf_i,
   input  wire logic              evt_rx_poison_cpl_i,
   input  wire logic              evt_tx_poison_wr_i,
   input  wire logic              evt_tx_ca_cpl_i,
   input  wire logic              evt_rx_ca_cpl_i,
   input  wire logic              evt_rx_ur_cpl_i,
   input  wire logic              evt_tx_err_msg_i,
   // Bus-master enable lookup
   input  wire logic [VF_W-1:0]   bm_vf_i,
   output logic                   bm_en_o
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [NUM_VF-1:0]                         bme;
      logic [NUM_VF-1:0][vfcfg_pkg::FLG_NUM-1:0] flags;
      logic [NUM_VF-1:0][31:0]                   tph_ctrl;
      logic [NUM_VF-1:0][15:0]                   ats_ctrl;
      logic [31:0]                               rdata;
      logic                                      bm_en;
   } vfcfg_state_s;

   vfcfg_state_s st_q;
   vfcfg_state_s st_d;

   // Command/Status word from one VF's stored bits
   function automatic logic [31:0] cmd_status_word(input logic bme, input logic [5:0] flg);
      logic [31:0] w;
      w = 32'h0000_0000;                                                   // [R17]
      w[vfcfg_pkg::CMD_BME_BIT]    = bme;
      w[vfcfg_pkg::STS_EXTCAP_BIT] = 1'b1;                                 // [R8]
      w[vfcfg_pkg::STS_MDPE_BIT]   = flg[vfcfg_pkg::FLG_MDPE];
      w[vfcfg_pkg::STS_STA_BIT]    = flg[vfcfg_pkg::FLG_STA];
      w[vfcfg_pkg::STS_RTA_BIT]    = flg[vfcfg_pkg::FLG_RTA];
      w[vfcfg_pkg::STS_RMA_BIT]    = flg[vfcfg_pkg::FLG_RMA];
      w[vfcfg_pkg::STS_SSE_BIT]    = flg[vfcfg_pkg::FLG_SSE];
      w[vfcfg_pkg::STS_RUR_BIT]    = flg[vfcfg_pkg::FLG_RUR];
      return w;
   endfunction

   // Write-one-to-clear mask taken from a Command/Status write
   function automatic logic [5:0] w1c_mask(input logic [31:0] wd);
      logic [5:0] m;
      m = 6'h00;
      m[vfcfg_pkg::FLG_MDPE] = wd[vfcfg_pkg::STS_MDPE_BIT];
      m[vfcfg_pkg::FLG_STA]  = wd[vfcfg_pkg::STS_STA_BIT];
      m[vfcfg_pkg::FLG_RTA]  = wd[vfcfg_pkg::STS_RTA_BIT];
      m[vfcfg_pkg::FLG_RMA]  = wd[vfcfg_pkg::STS_RMA_BIT];
      m[vfcfg_pkg::FLG_SSE]  = wd[vfcfg_pkg::STS_SSE_BIT];
      m[vfcfg_pkg::FLG_RUR]  = wd[vfcfg_pkg::STS_RUR_BIT];
      return m;
   endfunction

   // ***************************************************************
   // Event decode (one VF per cycle)
   // ***************************************************************
   logic [5:0] evt_set;

   always_comb begin
      evt_set = 6'h00;
      evt_set[vfcfg_pkg::FLG_MDPE] = (evt_rx_poison_cpl_i | evt_tx_poison_wr_i) & pf_perr_en_i;   // [R9]
      evt_set[vfcfg_pkg::FLG_STA]  = evt_tx_ca_cpl_i;                                            // [R10]
      evt_set[vfcfg_pkg::FLG_RTA]  = evt_rx_ca_cpl_i;                                            // [R11]
      evt_set[vfcfg_pkg::FLG_RMA]  = evt_rx_ur_cpl_i;                                            // [R12]
      evt_set[vfcfg_pkg::FLG_SSE]  = evt_tx_err_msg_i & pf_serr_en_i;                            // [R13]
      evt_set[vfcfg_pkg::FLG_RUR]  = evt_rx_ur_cpl_i;                                            // [R14]
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   logic wr_cmd;
   logic wr_tph;
   logic wr_ats;

   always_comb begin
      st_d   = st_q;
      wr_cmd = cfg_wr_i && (cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS);
      wr_tph = cfg_wr_i && (cfg_addr_i == vfcfg_pkg::OFS_TPH_CTRL);
      wr_ats = cfg_wr_i && (cfg_addr_i == vfcfg_pkg::OFS_ATS_CAP_CTRL);

      // Per-VF copies; set wins over a same-cycle clear
      for (int v = 0; v < NUM_VF; v++) begin                                             // [R16]
         if (wr_cmd && (cfg_vf_i == VF_W'(v))) begin
            st_d.bme[v]   = cfg_wdata_i[vfcfg_pkg::CMD_BME_BIT];                         // [R7]
            st_d.flags[v] = st_q.flags[v] & ~w1c_mask(cfg_wdata_i);                      // [R15]
         end
         if (wr_tph && (cfg_vf_i == VF_W'(v))) begin
            st_d.tph_ctrl[v] = cfg_wdata_i & vfcfg_pkg::TPH_CTRL_WMASK;                  // [R5] [R17]
         end
         if (wr_ats && (cfg_vf_i == VF_W'(v))) begin
            st_d.ats_ctrl[v] = cfg_wdata_i[31:16] & vfcfg_pkg::ATS_CTRL_WMASK;           // [R6] [R17]
         end
         if (evt_vf_i == VF_W'(v)) begin
            st_d.flags[v] = st_d.flags[v] | evt_set;                                     // [R15]
         end
      end

      // Bus-master enable lookup for the requester logic
      st_d.bm_en = st_q.bme[bm_vf_i];                                                    // [R7]

      // Read data, valid only the cycle after the strobe
      st_d.rdata = 32'h0000_0000;
      if (cfg_rd_i) begin
         case (cfg_addr_i)
            vfcfg_pkg::OFS_CMD_STATUS:
               st_d.rdata = cmd_status_word(st_q.bme[cfg_vf_i], st_q.flags[cfg_vf_i]);
            vfcfg_pkg::OFS_DEV_CAPS2:
               st_d.rdata = pf_dev_caps2_i;                                              // [R1]
            vfcfg_pkg::OFS_DEV_CTRL2,
            vfcfg_pkg::OFS_LINK_CAPS2,
            vfcfg_pkg::OFS_ARI_CAP_CTRL:
               st_d.rdata = 32'h0000_0000;                                               // [R2]
            vfcfg_pkg::OFS_LINK_CTRL2:
               st_d.rdata[vfcfg_pkg::DEEMPH_BIT] = pf_deemph_i;                          // [R3]
            vfcfg_pkg::OFS_ARI_HEADER:
               st_d.rdata = {vfcfg_pkg::NEXT_NULL, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::ARI_CAP_ID};   // [R4]
            vfcfg_pkg::OFS_TPH_HEADER:
               st_d.rdata = {vfcfg_pkg::TPH_NEXT_PTR, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::TPH_CAP_ID}; // [R5]
            vfcfg_pkg::OFS_TPH_CAP:
               st_d.rdata = vfcfg_pkg::TPH_CAP_VAL;                                      // [R5]
            vfcfg_pkg::OFS_TPH_CTRL:
               st_d.rdata = st_q.tph_ctrl[cfg_vf_i];                                     // [R5]
            vfcfg_pkg::OFS_ATS_HEADER:
               st_d.rdata = {vfcfg_pkg::NEXT_NULL, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::ATS_CAP_ID};   // [R6]
            vfcfg_pkg::OFS_ATS_CAP_CTRL:
               st_d.rdata = {st_q.ats_ctrl[cfg_vf_i], vfcfg_pkg::ATS_CAP_VAL};           // [R6]
            default:
               st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q.bme      <= {NUM_VF{vfcfg_pkg::BME_RST}};                                  // [R7]
         st_q.flags    <= {NUM_VF{vfcfg_pkg::FLAGS_RST}};                                // [R15]
         st_q.tph_ctrl <= {NUM_VF{vfcfg_pkg::TPH_CTRL_RST}};
         st_q.ats_ctrl <= {NUM_VF{vfcfg_pkg::ATS_CTRL_RST}};
         st_q.rdata    <= 32'h0000_0000;
         st_q.bm_en    <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cfg_rdata_o = st_q.rdata;
   assign bm_en_o     = st_q.bm_en;

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_dcap_mirror: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R1]
      (cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_DEV_CAPS2) |=> (cfg_rdata_o == $past(pf_dev_caps2_i)))
      else $error("Device caps 2 read does not mirror PF");

   a_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R2]
      (cfg_rd_i && (cfg_addr_i == vfcfg_pkg::OFS_DEV_CTRL2 || cfg_addr_i == vfcfg_pkg::OFS_LINK_CAPS2
                    || cfg_addr_i == vfcfg_pkg::OFS_ARI_CAP_CTRL)) |=> (cfg_rdata_o == 32'h0000_0000))
      else $error("Unimplemented location read nonzero");

   a_deemph_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R3]
      (cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_LINK_CTRL2)
      |=> (cfg_rdata_o == {15'h0000, $past(pf_deemph_i), 16'h0000}))
      else $error("Link control 2 word wrong");

   a_ari_header: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R4]
      (cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_ARI_HEADER)
      |=> (cfg_rdata_o[31:20] == 12'h000 && cfg_rdata_o[15:0] == vfcfg_pkg::ARI_CAP_ID))
      else $error("ARI header wrong");

   a_ats_cap_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R6]
      (cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_ATS_CAP_CTRL) |=> (cfg_rdata_o[15:0] == vfcfg_pkg::ATS_CAP_VAL))
      else $error("ATS capability field wrong");

   a_cmd_fixed_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R8]
      (cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS)
      |=> (cfg_rdata_o[20] == 1'b1 && cfg_rdata_o[19:3] == 17'h00000 && cfg_rdata_o[1:0] == 2'h0))
      else $error("Command/Status fixed bits wrong");

   a_bme_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R7]
      (cfg_wr_i && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS)
      ##1 (bm_vf_i == $past(cfg_vf_i) && !(cfg_wr_i && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS))
      |=> (bm_en_o == $past(cfg_wdata_i[2], 2)))
      else $error("Bus-master enable not taken from write");

   a_poison_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R9]
      ((evt_rx_poison_cpl_i || evt_tx_poison_wr_i) && pf_perr_en_i)
      |=> st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_MDPE])
      else $error("Poison event did not set flag");

   a_ur_both: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R12] [R14]
      evt_rx_ur_cpl_i
      |=> (st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_RMA] && st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_RUR]))
      else $error("UR completion did not set both flags");

   a_sse_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R13]
      (!pf_serr_en_i && !st_q.flags[evt_vf_i][vfcfg_pkg::FLG_SSE])
      |=> !st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_SSE])
      else $error("System error flag set while SERR disabled");

   a_w1c_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)   // [R15]
      (cfg_wr_i && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS && cfg_wdata_i[27]
       && !(evt_tx_ca_cpl_i && evt_vf_i == cfg_vf_i))
      |=> !st_q.flags[$past(cfg_vf_i)][vfcfg_pkg::FLG_STA])
      else $error("Write one did not clear flag");

   a_rdata_idle: assert property (   // [R17]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !cfg_rd_i
      |=>
      (cfg_rdata_o == 32'h0000_0000))
      else $error("Read data not zero when idle");

   a_tph_header: assert property (   // [R5]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_TPH_HEADER
      |=> (cfg_rdata_o[15:0] == vfcfg_pkg::TPH_CAP_ID
           && cfg_rdata_o[31:20] == vfcfg_pkg::TPH_NEXT_PTR))
      else $error("TPH header wrong");

   a_tph_cap_word: assert property (   // [R5]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i
      && cfg_addr_i == vfcfg_pkg::OFS_TPH_CAP
      |=> (cfg_rdata_o == vfcfg_pkg::TPH_CAP_VAL))
      else $error("TPH capability wrong");

   a_ats_header: assert property (   // [R6]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i && cfg_addr_i == vfcfg_pkg::OFS_ATS_HEADER
      |=> (cfg_rdata_o[15:0] == vfcfg_pkg::ATS_CAP_ID
           && cfg_rdata_o[31:20] == vfcfg_pkg::NEXT_NULL))
      else $error("ATS header wrong");

   a_tph_ctrl_mask: assert property (   // [R17]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i
      && cfg_addr_i == vfcfg_pkg::OFS_TPH_CTRL
      |=> ((cfg_rdata_o & ~vfcfg_pkg::TPH_CTRL_WMASK) == 32'h0000_0000))
      else $error("TPH control fixed bits set");

   a_ats_ctrl_mask: assert property (   // [R17]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i
      && cfg_addr_i == vfcfg_pkg::OFS_ATS_CAP_CTRL
      |=> ((cfg_rdata_o[31:16] & ~vfcfg_pkg::ATS_CTRL_WMASK) == 16'h0000))
      else $error("ATS control fixed bits set");

   a_cmd_rsvd_bits: assert property (   // [R17]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i
      && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS
      |=> (cfg_rdata_o[23:21] == 3'h0 && cfg_rdata_o[26:25] == 2'h0))
      else $error("Command/Status reserved bits set");

   a_ari_version: assert property (   // [R4]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_rd_i
      && cfg_addr_i == vfcfg_pkg::OFS_ARI_HEADER
      |=> (cfg_rdata_o[19:16] == vfcfg_pkg::CAP_VERSION))
      else $error("ARI version wrong");

   a_sta_set: assert property (   // [R10]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      evt_tx_ca_cpl_i
      |=>
      st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_STA])
      else $error("Sent abort not flagged");

   a_rta_set: assert property (   // [R11]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      evt_rx_ca_cpl_i
      |=>
      st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_RTA])
      else $error("Received abort not flagged");

   a_sse_set: assert property (   // [R13]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      evt_tx_err_msg_i
      && pf_serr_en_i
      |=> st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_SSE])
      else $error("Error message not flagged");

   a_mdpe_gate: assert property (   // [R9]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !pf_perr_en_i
      && !st_q.flags[evt_vf_i][vfcfg_pkg::FLG_MDPE]
      |=> !st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_MDPE])
      else $error("Parity flag set while disabled");

   a_set_wins: assert property (   // [R15]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      evt_rx_ca_cpl_i && cfg_wr_i && cfg_vf_i == evt_vf_i
      && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS
      |=> st_q.flags[$past(evt_vf_i)][vfcfg_pkg::FLG_RTA])
      else $error("Clear beat same-cycle set");

   a_w1c_keep: assert property (   // [R15]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg_wr_i && cfg_addr_i == vfcfg_pkg::OFS_CMD_STATUS
      && !cfg_wdata_i[vfcfg_pkg::STS_RTA_BIT] && st_q.flags[cfg_vf_i][vfcfg_pkg::FLG_RTA]
      |=> st_q.flags[$past(cfg_vf_i)][vfcfg_pkg::FLG_RTA])
      else $error("Write zero cleared flag");

   a_flag_sticky: assert property (   // [R15]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !cfg_wr_i
      |=>
      ((st_q.flags & $past(st_q.flags)) == $past(st_q.flags)))
      else $error("Flag cleared without write");

   a_bme_hold: assert property (   // [R7]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !cfg_wr_i
      |=>
      (st_q.bme == $past(st_q.bme)))
      else $error("Bus-master enable changed without write");

   a_tph_hold: assert property (   // [R5]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !cfg_wr_i
      |=>
      (st_q.tph_ctrl == $past(st_q.tph_ctrl)))
      else $error("TPH control changed without write");

   a_ats_hold: assert property (   // [R6]
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !cfg_wr_i
      |=>
      (st_q.ats_ctrl == $past(st_q.ats_ctrl)))
      else $error("ATS control changed without write");

endmodule // vfcfg_regs

// ### vfcfg_host.sv
// Host model issuing configuration reads and writes
`timescale 1ns/10ps
module vfcfg_host (
   input  wire logic        clk_sys_i,
   input  wire logic [31:0] rdata_i,
   output logic      [1:0]  vf_o,
   output logic      [11:0] addr_o,
   output logic      [31:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   initial begin
      vf_o    = 2'h0;
      addr_o  = 12'h000;
      wdata_o = 32'h0000_0000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end

   // ***************************************************************
   // One-cycle write strobe; every field held through the sampling edge
   // ***************************************************************
   task automatic wr(input logic [1:0] vf, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      vf_o    <= vf;
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_sys_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask

   // ***************************************************************
   // One-cycle read strobe; data taken in the following cycle only
   // ***************************************************************
   task automatic rd(input logic [1:0] vf, input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      vf_o   <= vf;
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_sys_i);
      rd_o   <= 1'b0;
      #1;
      d = rdata_i;
   endtask
endmodule // vfcfg_host

// ### tb.sv
// Self-checking bench for the per-VF configuration register bank
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
   localparam logic [31:0] CAPS = 32'h5a5a_c3c3;
   localparam logic [31:0] ONES = 32'hffff_ffff;
   typedef struct packed { logic [11:0] a; logic [31:0] r; logic [31:0] e; } vfcfg_row_s;
   logic        clk_sys_i, rst_n_i, wr, rd, perr, serr, deemph, bm_en;
   logic [1:0]  vf, evt_vf, bm_vf;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, caps;
   logic [5:0]  evt;
   int          failures, n_compared;
   vfcfg_row_s  rows [12];

   vfcfg_host i_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .vf_o(vf), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   vfcfg_regs #(.NUM_VF(4)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_vf_i(vf),
      .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_rdata_o(rdata),
      .pf_dev_caps2_i(caps), .pf_deemph_i(deemph), .pf_perr_en_i(perr), .pf_serr_en_i(serr),
      .evt_vf_i(evt_vf), .evt_rx_poison_cpl_i(evt[5]), .evt_tx_poison_wr_i(evt[4]), .evt_tx_ca_cpl_i(evt[3]),
      .evt_rx_ca_cpl_i(evt[2]), .evt_rx_ur_cpl_i(evt[1]), .evt_tx_err_msg_i(evt[0]), .bm_vf_i(bm_vf),
      .bm_en_o(bm_en));

   task automatic rdchk(input logic [1:0] v, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      i_host.rd(v, a, d);
      `CHK(d, e)
   endtask

   // Event mask: rx poison, tx poison, tx CA, rx CA, rx UR, error message
   task automatic pulse(input logic [1:0] v, input logic [5:0] m);
      @(posedge clk_sys_i);
      evt_vf <= v;
      evt    <= m;
      @(posedge clk_sys_i);
      evt    <= 6'h00;
   endtask

   task automatic give_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      repeat (4000) @(posedge clk_sys_i);
      failures++;
      give_verdict();
   end

   initial begin
      rst_n_i = 1'b0;
      perr = 1'b0;
      serr = 1'b0;
      evt = 6'h00;
      evt_vf = 2'h0;
      bm_vf = 2'h1;
      caps = CAPS;
      deemph = 1'b1;
      failures = 0;
      n_compared = 0;
      // Offset, reset value, value after writing all ones
      rows = '{
         '{vfcfg_pkg::OFS_CMD_STATUS, 32'h0010_0000, 32'h0010_0004},
         '{vfcfg_pkg::OFS_DEV_CAPS2, CAPS, CAPS},
         '{vfcfg_pkg::OFS_DEV_CTRL2, 32'h0, 32'h0},
         '{vfcfg_pkg::OFS_LINK_CAPS2, 32'h0, 32'h0},
         '{vfcfg_pkg::OFS_LINK_CTRL2, 32'h0001_0000, 32'h0001_0000},
         '{vfcfg_pkg::OFS_ARI_HEADER, {vfcfg_pkg::NEXT_NULL, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::ARI_CAP_ID},
           {vfcfg_pkg::NEXT_NULL, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::ARI_CAP_ID}},
         '{vfcfg_pkg::OFS_ARI_CAP_CTRL, 32'h0, 32'h0},
         '{vfcfg_pkg::OFS_TPH_HEADER, {vfcfg_pkg::TPH_NEXT_PTR, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::TPH_CAP_ID},
           {vfcfg_pkg::TPH_NEXT_PTR, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::TPH_CAP_ID}},
         '{vfcfg_pkg::OFS_TPH_CAP, vfcfg_pkg::TPH_CAP_VAL, vfcfg_pkg::TPH_CAP_VAL},
         '{vfcfg_pkg::OFS_TPH_CTRL, vfcfg_pkg::TPH_CTRL_RST, vfcfg_pkg::TPH_CTRL_WMASK},
         '{vfcfg_pkg::OFS_ATS_HEADER, {vfcfg_pkg::NEXT_NULL, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::ATS_CAP_ID},
           {vfcfg_pkg::NEXT_NULL, vfcfg_pkg::CAP_VERSION, vfcfg_pkg::ATS_CAP_ID}},
         '{vfcfg_pkg::OFS_ATS_CAP_CTRL, {vfcfg_pkg::ATS_CTRL_RST, vfcfg_pkg::ATS_CAP_VAL},
           {vfcfg_pkg::ATS_CTRL_WMASK, vfcfg_pkg::ATS_CAP_VAL}}};
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      // ***************************************************************
      // Table: reset value, write all ones, read back
      // ***************************************************************
      foreach (rows[i]) begin
         rdchk(2'h1, rows[i].a, rows[i].r);
         i_host.wr(2'h1, rows[i].a, ONES);
         rdchk(2'h1, rows[i].a, rows[i].e);
      end
      // ***************************************************************
      // Per-VF copies and bus-master lookup
      // ***************************************************************
      rdchk(2'h2, vfcfg_pkg::OFS_CMD_STATUS, 32'h0010_0000);
      rdchk(2'h2, vfcfg_pkg::OFS_TPH_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys_i);
      #1 `CHK(bm_en, 1'b1)
      bm_vf <= 2'h2;
      repeat (2) @(posedge clk_sys_i);
      #1 `CHK(bm_en, 1'b0)
      caps   <= ~CAPS;
      deemph <= 1'b0;
      rdchk(2'h0, vfcfg_pkg::OFS_DEV_CAPS2, ~CAPS);
      rdchk(2'h3, vfcfg_pkg::OFS_LINK_CTRL2, 32'h0);
      // ***************************************************************
      // Error events, gated and ungated
      // ***************************************************************
      pulse(2'h3, 6'h3f);
      rdchk(2'h3, vfcfg_pkg::OFS_CMD_STATUS, 32'hb810_0000);
      pulse(2'h0, 6'h02);
      rdchk(2'h0, vfcfg_pkg::OFS_CMD_STATUS, 32'ha010_0000);
      perr <= 1'b1;
      serr <= 1'b1;
      pulse(2'h2, 6'h20);
      rdchk(2'h2, vfcfg_pkg::OFS_CMD_STATUS, 32'h0110_0000);
      pulse(2'h1, 6'h10);
      rdchk(2'h1, vfcfg_pkg::OFS_CMD_STATUS, 32'h0110_0004);
      pulse(2'h2, 6'h01);
      rdchk(2'h2, vfcfg_pkg::OFS_CMD_STATUS, 32'h4110_0000);
      // ***************************************************************
      // Write-one-clear, and set against clear in the same cycle
      // ***************************************************************
      i_host.wr(2'h3, vfcfg_pkg::OFS_CMD_STATUS, 32'h0800_0000);
      rdchk(2'h3, vfcfg_pkg::OFS_CMD_STATUS, 32'hb010_0000);
      i_host.wr(2'h3, vfcfg_pkg::OFS_CMD_STATUS, 32'h0);
      rdchk(2'h3, vfcfg_pkg::OFS_CMD_STATUS, 32'hb010_0000);
      i_host.wr(2'h3, vfcfg_pkg::OFS_CMD_STATUS, ONES);
      rdchk(2'h3, vfcfg_pkg::OFS_CMD_STATUS, 32'h0010_0004);
      fork
         i_host.wr(2'h0, vfcfg_pkg::OFS_CMD_STATUS, ONES);
         pulse(2'h0, 6'h04);
      join
      rdchk(2'h0, vfcfg_pkg::OFS_CMD_STATUS, 32'h1010_0004);
      // ***************************************************************
      // Reset in mid-run
      // ***************************************************************
      bm_vf <= 2'h1;
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1 `CHK(bm_en, 1'b0)
      rst_n_i <= 1'b1;
      rdchk(2'h1, vfcfg_pkg::OFS_CMD_STATUS, 32'h0010_0000);
      rdchk(2'h1, vfcfg_pkg::OFS_TPH_CTRL, vfcfg_pkg::TPH_CTRL_RST);
      give_verdict();
   end
endmodule // tb
